// file: hw/sbpc_defs.vh
// register addresses, reset values and field positions of the bias/power config bank
`ifndef SBPC_DEFS_VH
`define SBPC_DEFS_VH

// ****************************************
// register addresses (9-bit word address)
// ****************************************
`define SBPC_ADDR_W          9
`define SBPC_DATA_W          16
`define SBPC_A_DRV_TRIM      9'h044
`define SBPC_A_FE_REF        9'h046
`define SBPC_A_PUMP          9'h048
`define SBPC_A_SPARE_A       9'h050
`define SBPC_A_SPARE_B       9'h051
`define SBPC_A_THERM_CTL     9'h060
`define SBPC_A_THERM_RD      9'h061
`define SBPC_A_SER_PWR       9'h070
`define SBPC_A_BLACK         9'h080

// ****************************************
// reset values
// ****************************************
`define SBPC_R_DRV_TRIM      16'h0088
`define SBPC_R_FE_REF        16'h8888
`define SBPC_R_PUMP          16'h1200
`define SBPC_R_SPARE_A       16'h0000
`define SBPC_R_SPARE_B       16'h8881
`define SBPC_R_THERM_CTL     16'h0000
`define SBPC_R_SER_PWR       16'h0000
`define SBPC_R_BLACK         16'h4008
`define SBPC_R_ZERO          16'h0000

// ****************************************
// field positions
// ****************************************
`define SBPC_F_PD_PUMP_EN    0
`define SBPC_F_FD_PUMP_EN    1
`define SBPC_F_PD_TRIM       10:8
`define SBPC_F_FD_TRIM       14:12
`define SBPC_F_THERM_EN      0
`define SBPC_F_CLK_PWR       0
`define SBPC_F_SYNC_PWR      1
`define SBPC_F_DATA_PWR      2
`define SBPC_F_BLACK_LVL     7:0
`define SBPC_F_TEMP          7:0
`define SBPC_F_DRV_TRIM      7:0

// ****************************************
// readout padding and channel counts
// ****************************************
`define SBPC_R_TEMP          8'h00
`define SBPC_R_TEMP_PAD      8'h00
`define SBPC_N_DATA_CHAN     4

`endif

// file: hw/sbpc_regs.v
// configuration register bank for bias trims, pumps, thermal diode and serializer power
//
// Behaviour
// - pump register bit 0 enables photodiode-transfer charge pump; resets to 0.
// - pump register bit 1 enables floating-diffusion charge pump; resets to 0.
// - pump trims at bits 10:8 (reset 2) and 14:12 (reset 1); register 0x1200.
// - thermal control bit 0 turns the temperature diode on; resets to 0.
// - serializer power bit 0 powers the clock output channel; resets off.
// - serializer power bit 1 powers the sync output channel; resets off.
// - serializer power bit 2 powers all four data channels together; resets off.
// - black level register bits 7:0 set target black level; reset 0x08, register 0x4008.
`timescale 1ns/10ps
`include "sbpc_defs.vh"

module sbpc_regs (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rstn_in,
  // register access port (same clock domain as the configuration port)
  input  wire [8:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire [15:0] reg_wdata_in,
  output reg  [15:0] reg_rdata_out,
  // temperature value from the diode converter (same clock)
  input  wire [7:0]  temp_value_in,
  // analog controls
  output wire [7:0]  drv_current_trim_out,
  output wire [15:0] frontend_ref_trim_out,
  output wire        pd_pump_en_out,
  output wire        fd_pump_en_out,
  output wire [2:0]  pd_pump_trim_out,
  output wire [2:0]  fd_pump_trim_out,
  output wire        therm_diode_en_out,
  output wire        clk_chan_pwr_out,
  output wire        sync_chan_pwr_out,
  output wire [3:0]  data_chan_pwr_out,
  output wire [7:0]  black_level_out
);

  // ****************************************
  // storage
  // ****************************************

  // bias trim words
  reg [15:0] drv_trim_reg;
  reg [15:0] fe_ref_reg;

  // charge pump enables and trims
  reg [15:0] pump_reg;

  // spare words, stored and read back in full
  reg [15:0] spare_a_reg;
  reg [15:0] spare_b_reg;

  // thermal diode control and its sampled reading
  reg [15:0] therm_ctl_reg;
  reg [7:0]  temp_reg;

  // serializer channel power and black level target
  reg [15:0] ser_pwr_reg;
  reg [15:0] black_reg;

  // read mux result, loaded into the read data flop
  reg [15:0] rdata_next;

  // ****************************************
  // address decode
  // ****************************************

  // address match helper used by the write decode; the read mux decodes with a case
  function hit;
    input [8:0] a;
    input [8:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // one write strobe per writable word; the readout word has none
  wire       wr_drv_trim;
  wire       wr_fe_ref;
  wire       wr_pump;
  wire       wr_spare_a;
  wire       wr_spare_b;
  wire       wr_therm_ctl;
  wire       wr_ser_pwr;
  wire       wr_black;

  // strobes qualify the address with the write pulse
  assign wr_drv_trim  = reg_wr_in & hit(reg_addr_in, `SBPC_A_DRV_TRIM);
  assign wr_fe_ref    = reg_wr_in & hit(reg_addr_in, `SBPC_A_FE_REF);
  assign wr_pump      = reg_wr_in & hit(reg_addr_in, `SBPC_A_PUMP);
  assign wr_spare_a   = reg_wr_in & hit(reg_addr_in, `SBPC_A_SPARE_A);
  assign wr_spare_b   = reg_wr_in & hit(reg_addr_in, `SBPC_A_SPARE_B);
  assign wr_therm_ctl = reg_wr_in & hit(reg_addr_in, `SBPC_A_THERM_CTL);
  assign wr_ser_pwr   = reg_wr_in & hit(reg_addr_in, `SBPC_A_SER_PWR);
  assign wr_black     = reg_wr_in & hit(reg_addr_in, `SBPC_A_BLACK);

  // ****************************************
  // bias trim words
  // ****************************************

  // output driver current trim word
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drv_trim_reg <= `SBPC_R_DRV_TRIM;
    end else if (wr_drv_trim) begin
      drv_trim_reg <= reg_wdata_in;
    end
  end

  // front-end reference trim word
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fe_ref_reg <= `SBPC_R_FE_REF;
    end else if (wr_fe_ref) begin
      fe_ref_reg <= reg_wdata_in;
    end
  end

  // ****************************************
  // charge pumps
  // ****************************************

  // pump word: both enables off and trims at defaults after reset
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pump_reg <= `SBPC_R_PUMP;
    end else if (wr_pump) begin
      pump_reg <= reg_wdata_in;
    end
  end

  // ****************************************
  // spare words
  // ****************************************

  // first spare word
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spare_a_reg <= `SBPC_R_SPARE_A;
    end else if (wr_spare_a) begin
      spare_a_reg <= reg_wdata_in;
    end
  end

  // second spare word
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spare_b_reg <= `SBPC_R_SPARE_B;
    end else if (wr_spare_b) begin
      spare_b_reg <= reg_wdata_in;
    end
  end

  // ****************************************
  // thermal diode
  // ****************************************

  // diode enable word; diode is off after reset
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      therm_ctl_reg <= `SBPC_R_THERM_CTL;
    end else if (wr_therm_ctl) begin
      therm_ctl_reg <= reg_wdata_in;
    end
  end

  // temperature sample refreshes every cycle; no write path reaches it
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      temp_reg <= `SBPC_R_TEMP;
    end else begin
      temp_reg <= temp_value_in;
    end
  end

  // ****************************************
  // serializer power
  // ****************************************

  // channel power word; every channel is powered down after reset
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ser_pwr_reg <= `SBPC_R_SER_PWR;
    end else if (wr_ser_pwr) begin
      ser_pwr_reg <= reg_wdata_in;
    end
  end

  // ****************************************
  // black level
  // ****************************************

  // black level target word
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      black_reg <= `SBPC_R_BLACK;
    end else if (wr_black) begin
      black_reg <= reg_wdata_in;
    end
  end

  // ****************************************
  // read path
  // ****************************************

  // read mux; unmapped addresses read as zero
  always @* begin
    case (reg_addr_in)
      `SBPC_A_DRV_TRIM: begin
        rdata_next = drv_trim_reg;
      end
      `SBPC_A_FE_REF: begin
        rdata_next = fe_ref_reg;
      end
      `SBPC_A_PUMP: begin
        rdata_next = pump_reg;
      end
      `SBPC_A_SPARE_A: begin
        rdata_next = spare_a_reg;
      end
      `SBPC_A_SPARE_B: begin
        rdata_next = spare_b_reg;
      end
      `SBPC_A_THERM_CTL: begin
        rdata_next = therm_ctl_reg;
      end
      `SBPC_A_THERM_RD: begin
        rdata_next = {`SBPC_R_TEMP_PAD, temp_reg};
      end
      `SBPC_A_SER_PWR: begin
        rdata_next = ser_pwr_reg;
      end
      `SBPC_A_BLACK: begin
        rdata_next = black_reg;
      end
      default: begin
        rdata_next = `SBPC_R_ZERO;
      end
    endcase
  end

  // read data registered one cycle after the address
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= `SBPC_R_ZERO;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  // ****************************************
  // field outputs
  // ****************************************

  // trims and enables straight from their words
  assign drv_current_trim_out  = drv_trim_reg[`SBPC_F_DRV_TRIM];
  assign frontend_ref_trim_out = fe_ref_reg;
  assign pd_pump_en_out        = pump_reg[`SBPC_F_PD_PUMP_EN];
  assign fd_pump_en_out        = pump_reg[`SBPC_F_FD_PUMP_EN];
  assign pd_pump_trim_out      = pump_reg[`SBPC_F_PD_TRIM];
  assign fd_pump_trim_out      = pump_reg[`SBPC_F_FD_TRIM];
  assign therm_diode_en_out    = therm_ctl_reg[`SBPC_F_THERM_EN];
  assign clk_chan_pwr_out      = ser_pwr_reg[`SBPC_F_CLK_PWR];
  assign sync_chan_pwr_out     = ser_pwr_reg[`SBPC_F_SYNC_PWR];
  assign black_level_out       = black_reg[`SBPC_F_BLACK_LVL];

  // one power bit fans out to every data channel so they never split
  genvar ch;
  generate
    for (ch = 0; ch < `SBPC_N_DATA_CHAN; ch = ch + 1) begin : g_data_chan
      assign data_chan_pwr_out[ch] = ser_pwr_reg[`SBPC_F_DATA_PWR];
    end
  endgenerate

endmodule

// file: verif/sbpc_regs_properties.sv
// concurrent checks on the bias and power configuration bank
`timescale 1ns/10ps
module sbpc_regs_properties (
  input wire        mclk_in, rstn_in, reg_wr_in, pd_pump_en_out, fd_pump_en_out,
  input wire        therm_diode_en_out, clk_chan_pwr_out, sync_chan_pwr_out,
  input wire [8:0]  reg_addr_in,
  input wire [15:0] reg_wdata_in, reg_rdata_out,
  input wire [7:0]  temp_value_in, black_level_out,
  input wire [2:0]  pd_pump_trim_out, fd_pump_trim_out,
  input wire [3:0]  data_chan_pwr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // decoded write strobes
  wire wp = reg_wr_in && reg_addr_in == 9'h048;
  wire ws = reg_wr_in && reg_addr_in == 9'h070;
  pump_en_a: assert property (wp |=> {fd_pump_en_out, pd_pump_en_out} == $past(reg_wdata_in[1:0]))
    else $error("pump enable mismatch");
  pump_trim_a: assert property (wp |=> {fd_pump_trim_out, pd_pump_trim_out} ==
    {$past(reg_wdata_in[14:12]), $past(reg_wdata_in[10:8])}) else $error("pump trim mismatch");
  pump_hold_a: assert property (!wp |=> $stable({fd_pump_trim_out, pd_pump_trim_out}))
    else $error("pump trim changed without write");
  diode_en_a: assert property (reg_wr_in && reg_addr_in == 9'h060 |=>
    therm_diode_en_out == $past(reg_wdata_in[0])) else $error("diode enable mismatch");
  ser_pwr_a: assert property (ws |=> {data_chan_pwr_out, sync_chan_pwr_out, clk_chan_pwr_out} ==
    {{4{$past(reg_wdata_in[2])}}, $past(reg_wdata_in[1:0])}) else $error("power bits mismatch");
  data_group_a: assert property (data_chan_pwr_out == 4'h0 || data_chan_pwr_out == 4'hf)
    else $error("data channels split");
  black_lvl_a: assert property (reg_wr_in && reg_addr_in == 9'h080 |=>
    black_level_out == $past(reg_wdata_in[7:0])) else $error("black level mismatch");
  temp_read_a: assert property (reg_addr_in == 9'h061 && $past(rstn_in) |=>
    reg_rdata_out == {8'h00, $past(temp_value_in, 2)}) else $error("temperature readout mismatch");
  // main scenarios reached
  cover property (wp);
  cover property (ws && reg_wdata_in[2]);
  cover property (reg_addr_in == 9'h061);
endmodule
bind sbpc_regs sbpc_regs_properties sbpc_regs_properties_inst (.*);

// file: verif/testbench.sv
// self-checking bench for the bias and power configuration bank
`timescale 1ns/10ps
module testbench;
  logic        mclk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0;
  logic [8:0]  reg_addr_in = 9'h044;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, r, frontend_ref_trim_out;
  logic [7:0]  temp_value_in = 8'h5c, drv_current_trim_out, black_level_out;
  logic        pd_pump_en_out, fd_pump_en_out, therm_diode_en_out, clk_chan_pwr_out;
  logic        sync_chan_pwr_out;
  logic [2:0]  pd_pump_trim_out, fd_pump_trim_out;
  logic [3:0]  data_chan_pwr_out;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  // rows: address, write data, expected read back
  logic [40:0] rows [10] = '{{9'h044, 16'h1234, 16'h1234}, {9'h046, 16'h5a5a, 16'h5a5a},
    {9'h048, 16'h7703, 16'h7703}, {9'h050, 16'habcd, 16'habcd}, {9'h051, 16'h0f0f, 16'h0f0f},
    {9'h060, 16'h0001, 16'h0001}, {9'h061, 16'hffff, 16'h005c}, {9'h070, 16'h0005, 16'h0005},
    {9'h080, 16'h40c3, 16'h40c3}, {9'h055, 16'hffff, 16'h0000}};
  wire [22:0]  flds = {pd_pump_en_out, fd_pump_en_out, pd_pump_trim_out, fd_pump_trim_out,
    therm_diode_en_out, clk_chan_pwr_out, sync_chan_pwr_out, data_chan_pwr_out, black_level_out};
  sbpc_regs sbpc_regs_inst (.*);
  always #2 mclk_in = ~mclk_in;
  // cycle ceiling against hangs
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // write leaves the strobe high so back-to-back writes need no gap
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge mclk_in);
  endtask
  task automatic rd(input logic [8:0] a);
    reg_wr_in = 1'b0;
    reg_addr_in = a;
    @(negedge mclk_in);
    r = reg_rdata_out;
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge mclk_in);
    rstn_in = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][40:32], rows[i][31:16]);
      rd(rows[i][40:32]);
      chk("readback", r, rows[i][15:0]);
    end
    chk("fields", flds, {2'b11, 3'h7, 3'h7, 3'b110, 4'hf, 8'hc3});
    chk("trims", {drv_current_trim_out, frontend_ref_trim_out}, {8'h34, 16'h5a5a});
    wr(9'h070, 16'h0007);
    wr(9'h070, 16'h0002);
    reg_wr_in = 1'b0;
    chk("power", {clk_chan_pwr_out, sync_chan_pwr_out, data_chan_pwr_out}, 6'h10);
    rstn_in = 1'b0;
    @(negedge mclk_in);
    chk("reset fields", {drv_current_trim_out, flds}, {8'h88, 2'b00, 3'h2, 3'h1, 15'h0008});
    chk("reset rdata", {frontend_ref_trim_out, reg_rdata_out}, {16'h8888, 16'h0000});
    rstn_in = 1'b1;
    rd(9'h048);
    chk("pump reset", r, 16'h1200);
    rd(9'h080);
    chk("black reset", r, 16'h4008);
    tally_and_finish();
  end
endmodule
